// >>> rtl/ssp_host.sv
// master side of the serial port: clock divider and frame sequencer
`timescale 1ns/10ps
`default_nettype none
module ssp_host
    import ssp_pkg::*;
#(
    parameter int SCLK_HALF = SCLK_HALF_CYC,
    parameter int LEN_W = 4
)
(
    input wire logic clk,
    input wire logic rst,
    ssp_link_if.host link,
    input wire logic cmd_start,
    input wire logic cmd_rnw,
    input wire logic [6:0] cmd_addr,
    input wire logic [LEN_W-1:0] cmd_len,
    input wire logic cmd_mode11,
    input wire logic three_wire,
    input wire logic [7:0] wr_data,
    output logic busy,
    output logic wr_take,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic done
);
    // the device needs about four cycles to see an edge and answer it
    if (SCLK_HALF < SCLK_HALF_MIN || SCLK_HALF > 255 || LEN_W < 1) begin : g_bad
        $error("ssp_host: unsupported parameter values");
    end

    localparam logic [7:0] HALF_LAST = 8'(SCLK_HALF - 1);

    typedef struct packed {
        ssp_hst_t st;
        logic [7:0] cnt;
        logic [2:0] bit_cnt;
        logic [LEN_W-1:0] left;
        logic ctrl;
        logic rnw;
        logic mode11;
        logic tw;
        logic cs_n;
        logic sck;
        logic mosi;
        logic mosi_oe;
        logic [7:0] sh;
        logic [1:0] din_s;
        logic [7:0] rd_data;
        logic rd_valid;
        logic wr_take;
        logic done;
    } ssp_host_st_t;

    localparam ssp_host_st_t ST_RESET = '{st: H_IDLE, cs_n: 1'b1, default: '0};

    ssp_host_st_t q;
    ssp_host_st_t n;
    logic tick;
    logic [7:0] nsh;

    assign tick = (q.cnt == HALF_LAST);

    always_comb begin
        n = q;
        nsh = q.sh;
        n.rd_valid = 1'b0;
        n.wr_take = 1'b0;
        n.done = 1'b0;
        n.cnt = tick ? '0 : q.cnt + 8'h01;
        // input bit picked per wiring before the synchroniser
        n.din_s = {q.din_s[0], q.tw ? link.sdx : link.sdo};
        case (q.st)
            H_IDLE: begin
                n.cnt = '0;
                n.cs_n = 1'b1;
                n.mosi_oe = 1'b0;
                if (cmd_start) begin
                    // three-wire forces idle-high clock at select edges
                    n.mode11 = cmd_mode11 | three_wire;
                    n.sck = cmd_mode11 | three_wire;
                    n.tw = three_wire;
                    n.rnw = cmd_rnw;
                    n.sh = {cmd_rnw, cmd_addr};
                    n.left = cmd_len;
                    n.ctrl = 1'b1;
                    n.bit_cnt = '0;
                    n.st = H_SETUP;
                end
            end
            H_SETUP: begin
                if (tick) begin
                    n.cs_n = 1'b0;
                    n.mosi = q.sh[7];
                    n.mosi_oe = 1'b1;
                    n.st = H_LEAD;
                end
            end
            H_LEAD: begin
                if (tick) begin
                    n.sck = 1'b0;
                    n.st = H_LOW;
                end
            end
            H_LOW: begin
                if (tick) begin
                    n.sck = 1'b1;
                    n.st = H_HIGH;
                end
            end
            H_HIGH: begin
                if (tick) begin
                    // synchronised copy of the bit present at the rising edge
                    nsh = {q.sh[6:0], q.din_s[1]};
                    n.bit_cnt = q.bit_cnt + 3'h1;
                    n.st = H_LOW;
                    if (q.bit_cnt == BIT_LAST) begin
                        if (q.ctrl) begin
                            n.ctrl = 1'b0;
                            if (!q.rnw) begin
                                nsh = wr_data;
                                n.wr_take = 1'b1;
                            end
                        end else begin
                            n.left = q.left - 1'b1;
                            if (q.rnw) begin
                                n.rd_data = nsh;
                                n.rd_valid = 1'b1;
                            end
                            if (q.left <= 1) begin
                                n.st = H_TAIL;
                            end else if (!q.rnw) begin
                                nsh = wr_data;
                                n.wr_take = 1'b1;
                            end
                        end
                    end
                    n.sh = nsh;
                    n.sck = (n.st == H_TAIL) ? q.mode11 : 1'b0;
                    n.mosi = nsh[7];
                    // three-wire read: release the shared pin after control
                    n.mosi_oe = ~q.tw | ~q.rnw | (q.ctrl && q.bit_cnt != BIT_LAST);
                end
            end
            H_TAIL: begin
                if (tick) begin
                    n.cs_n = 1'b1;
                    n.mosi_oe = 1'b0;
                    n.st = H_GAP;
                end
            end
            H_GAP: begin
                if (tick) begin
                    n.done = 1'b1;
                    n.st = H_IDLE;
                end
            end
            default: begin
                n = ST_RESET;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= ST_RESET;
        end else begin
            q <= n;
        end
    end

    assign link.chip_select_n = q.cs_n;
    assign link.sclk = q.sck;
    assign link.host_sdx_o = q.mosi;
    assign link.host_sdx_oe = q.mosi_oe;
    assign busy = (q.st != H_IDLE);
    assign wr_take = q.wr_take;
    assign rd_data = q.rd_data;
    assign rd_valid = q.rd_valid;
    assign done = q.done;
endmodule
`default_nettype wire

// >>> inc/ssp_pkg.sv
// shared constants and types for the sensor serial port link
package ssp_pkg;
    // timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int SCLK_PERIOD_NS = 800;
    localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int SCLK_HALF_MIN = 4;
    // frame layout
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam int RNW_POS = 7;
    localparam logic [6:0] ADDR_STEP = 7'h01;
    // register addresses of the port; only the interface config one is decoded inside it
    localparam logic [6:0] ADDR_INTERFACE_CONFIG = 7'h6B;
    localparam logic [6:0] ADDR_NONVOLATILE_CONFIG = 7'h70;
    localparam logic [6:0] ADDR_DUMMY = 7'h7F;
    localparam int THREE_WIRE_BIT = 0;
    localparam int SPI_LOCK_BIT = 0;
    // master sequencer states
    typedef enum logic [2:0] {
        H_IDLE,
        H_SETUP,
        H_LEAD,
        H_LOW,
        H_HIGH,
        H_TAIL,
        H_GAP
    } ssp_hst_t;
endpackage

// >>> inc/ssp_link_if.sv
// serial link wires between master and sensor port
`timescale 1ns/10ps
`default_nettype none
interface ssp_link_if;
    logic chip_select_n;
    logic sclk;
    logic host_sdx_o;
    logic host_sdx_oe;
    logic dev_sdx_o;
    logic dev_sdx_oe;
    logic dev_sdo_o;
    logic dev_sdo_oe;
    logic sdx;
    logic sdo;
    // resolved pin levels; an undriven line floats high here
    assign sdx = dev_sdx_oe ? dev_sdx_o : (host_sdx_oe ? host_sdx_o : 1'b1);
    assign sdo = dev_sdo_oe ? dev_sdo_o : 1'b1;
    modport dev (
        input chip_select_n,
        input sclk,
        input sdx,
        output dev_sdx_o,
        output dev_sdx_oe,
        output dev_sdo_o,
        output dev_sdo_oe
    );
    modport host (
        output chip_select_n,
        output sclk,
        output host_sdx_o,
        output host_sdx_oe,
        input sdx,
        input sdo
    );
endinterface
`default_nettype wire

// >>> rtl/ssp_device.sv
// sensor side of the serial port: frame decoder, register access, pin drive
`timescale 1ns/10ps
`default_nettype none
module ssp_device
    import ssp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    ssp_link_if.dev link,
    input wire logic nv_spi_lock,
    output logic [6:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata,
    output logic spi_active,
    output logic three_wire,
    output logic mode11
);
    // port state, all in one register stage:
    //   cs_s, sck_s: select and clock, two sync stages plus an edge stage
    //   din_s: incoming data, two sync stages
    //   init_done, spi_on: lock strap caught, serial mode locked in
    //   three_wire, mode11: pin use and clock polarity of this frame
    //   in_frame, ctrl_phase, rnw, bit_cnt: frame progress
    //   addr, sh: current register and shift register
    //   driving, dout: read bit on the pin
    //   rq_addr, wdata, wr, rd, load_pend: register side access
    typedef struct packed {
        logic [2:0] cs_s;
        logic [2:0] sck_s;
        logic [1:0] din_s;
        logic init_done;
        logic spi_on;
        logic three_wire;
        logic mode11;
        logic in_frame;
        logic ctrl_phase;
        logic rnw;
        logic driving;
        logic dout;
        logic load_pend;
        logic [2:0] bit_cnt;
        logic [6:0] addr;
        logic [7:0] sh;
        logic [6:0] rq_addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ssp_dev_st_t;

    // select synchroniser idles high so reset makes no false edge
    localparam ssp_dev_st_t ST_RESET = '{cs_s: 3'h7, default: '0};

    ssp_dev_st_t q;
    ssp_dev_st_t n;
    logic cs_fall;
    logic cs_rise;
    logic sck_rise;
    logic sck_fall;
    logic [7:0] full;
    logic in_window;
    logic byte_end;
    logic ctrl_end;
    logic data_end;
    logic [6:0] addr_inc;
    logic rd_start;
    logic drive_bit;

    // edges are taken between the second and third stage only
    // every pin edge is seen three cycles late, so each clock half needs four cycles
    assign cs_fall = q.cs_s[2] & ~q.cs_s[1];
    assign cs_rise = ~q.cs_s[2] & q.cs_s[1];
    assign sck_rise = ~q.sck_s[2] & q.sck_s[1];
    assign sck_fall = q.sck_s[2] & ~q.sck_s[1];
    assign full = {q.sh[6:0], q.din_s[1]};

    // frame phases; only edges inside a low select window count
    assign in_window = q.in_frame & ~q.cs_s[1];
    assign byte_end = sck_rise & (q.bit_cnt == BIT_LAST);
    assign ctrl_end = byte_end & q.ctrl_phase;
    assign data_end = byte_end & ~q.ctrl_phase;
    // one incrementer serves read prefetch and write stepping
    assign addr_inc = q.addr + ADDR_STEP;
    // nothing is acted on until the port is locked to serial
    assign rd_start = full[RNW_POS] & q.spi_on;
    // read bits leave only once the control byte is complete
    assign drive_bit = sck_fall & q.rnw & ~q.ctrl_phase & q.spi_on;

    // next state of the whole port
    always_comb begin
        n = q;
        // strobes and the load request are single-cycle pulses
        n.wr = 1'b0;
        n.rd = 1'b0;
        n.load_pend = 1'b0;
        n.cs_s = {q.cs_s[1:0], link.chip_select_n};
        n.sck_s = {q.sck_s[1:0], link.sclk};
        n.din_s = {q.din_s[0], link.sdx};
        // lock strap is caught once, the first cycle after reset
        if (!q.init_done) begin
            n.init_done = 1'b1;
            n.spi_on = nv_spi_lock;
        end
        // read data is taken in the same cycle as the read strobe
        if (q.load_pend) begin
            n.sh = reg_rdata;
        end
        if (cs_rise) begin
            n.spi_on = 1'b1;
            n.in_frame = 1'b0;
            n.driving = 1'b0;
        end else if (cs_fall) begin
            n.in_frame = 1'b1;
            n.mode11 = q.sck_s[1];
            n.ctrl_phase = 1'b1;
            n.bit_cnt = '0;
            n.driving = 1'b0;
        end else if (in_window) begin
            // sample incoming bit on rising clock
            if (sck_rise) begin
                n.sh = full;
                n.bit_cnt = q.bit_cnt + 3'h1;
            end
            // control byte done: latch direction and start address
            if (ctrl_end) begin
                n.ctrl_phase = 1'b0;
                n.rnw = full[RNW_POS];
                n.addr = full[6:0];
                if (rd_start) begin
                    n.rq_addr = full[6:0];
                    n.rd = 1'b1;
                    n.load_pend = 1'b1;
                end
            end
            // read byte done: prefetch the next register of the burst
            if (data_end && q.rnw) begin
                n.addr = addr_inc;
                n.rq_addr = addr_inc;
                n.rd = q.spi_on;
                n.load_pend = q.spi_on;
            end
            // write byte done: strobe it out, then step the address
            if (data_end && !q.rnw) begin
                n.rq_addr = q.addr;
                n.wdata = full;
                n.wr = q.spi_on;
                n.addr = addr_inc;
                if (q.spi_on && q.addr == ADDR_INTERFACE_CONFIG) begin
                    n.three_wire = full[THREE_WIRE_BIT];
                end
            end
            // read data leaves on falling clock, only after the control byte
            if (drive_bit) begin
                n.driving = 1'b1;
                n.dout = q.sh[7];
            end
        end
    end

    // single register stage for all state
    always_ff @(posedge clk) begin
        if (rst) begin
            q <= ST_RESET;
        end else begin
            q <= n;
        end
    end

    // pin drive: output pin in four-wire, shared data pin in three-wire
    // one data register feeds both pins; only the enables differ, never both high
    assign link.dev_sdo_o = q.dout;
    assign link.dev_sdo_oe = q.driving & ~q.three_wire;
    assign link.dev_sdx_o = q.dout;
    assign link.dev_sdx_oe = q.driving & q.three_wire;

    // user side: register access strobes and status
    assign reg_addr = q.rq_addr;
    assign reg_wdata = q.wdata;
    assign reg_wr = q.wr;
    assign reg_rd = q.rd;
    assign spi_active = q.spi_on;
    assign three_wire = q.three_wire;
    assign mode11 = q.mode11;
endmodule
`default_nettype wire

// >>> tb/ssp_link_props.sv
// concurrent checks on the serial link wires between the two ends
`timescale 1ns/10ps
`default_nettype none
module ssp_link_props (
    input wire logic clk,
    input wire logic rst,
    input wire logic chip_select_n,
    input wire logic sclk,
    input wire logic host_sdx_o,
    input wire logic host_sdx_oe,
    input wire logic dev_sdx_o,
    input wire logic dev_sdx_oe,
    input wire logic dev_sdo_o,
    input wire logic dev_sdo_oe
);
    logic [7:0] rises_q;
    logic rnw_q;
    // count clock rises in a frame; the first captured bit tells read from write
    always_ff @(posedge clk) begin
        if (rst || chip_select_n) begin
            rises_q <= 8'h00;
        end else if ($rose(sclk)) begin
            rises_q <= rises_q + 8'h01;
        end
        if (rst) begin
            rnw_q <= 1'b0;
        end else if (!chip_select_n && $rose(sclk) && rises_q == 8'h00) begin
            rnw_q <= host_sdx_o;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_frame_rise;
        $rose(sclk) && !chip_select_n;
    endsequence
    sequence s_released;
        !dev_sdo_oe && !dev_sdx_oe;
    endsequence
    property p_cs_release;
        $rose(chip_select_n) |-> ##[1:6] s_released;
    endproperty
    a_cs_release: assert property (p_cs_release) else $error("device drives after select release");
    property p_pin_excl;
        !(dev_sdo_oe && dev_sdx_oe);
    endproperty
    a_pin_excl: assert property (p_pin_excl) else $error("device drives both data pins");
    property p_host_hold;
        s_frame_rise ##0 host_sdx_oe |=> $stable(host_sdx_o) [*3];
    endproperty
    a_host_hold: assert property (p_host_hold) else $error("master data moved while clock high");
    property p_dev_hold;
        s_frame_rise ##0 (dev_sdo_oe || dev_sdx_oe) |=> ($stable(dev_sdo_o) && $stable(dev_sdx_o)) [*3];
    endproperty
    a_dev_hold: assert property (p_dev_hold) else $error("device data moved while clock high");
    property p_dev_change_low;
        dev_sdo_oe && $past(dev_sdo_oe) && $changed(dev_sdo_o) |-> !sclk;
    endproperty
    a_dev_change_low: assert property (p_dev_change_low) else $error("device data changed with clock high");
    property p_cs3w_high;
        $changed(chip_select_n) && $past(dev_sdx_oe) |-> sclk;
    endproperty
    a_cs3w_high: assert property (p_cs3w_high) else $error("select moved with clock low on shared pin");
    property p_frame_len;
        $rose(chip_select_n) |-> rises_q[2:0] == 3'h0 && rises_q >= 8'h10;
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame not whole bytes of at least two");
    property p_write_no_drive;
        !chip_select_n && rises_q != 8'h00 && !rnw_q |-> s_released;
    endproperty
    a_write_no_drive: assert property (p_write_no_drive) else $error("device drives during a write");
    property p_drive_after_ctrl;
        $rose(dev_sdo_oe) || $rose(dev_sdx_oe) |-> rises_q >= 8'h08 && rnw_q && !chip_select_n;
    endproperty
    a_drive_after_ctrl: assert property (p_drive_after_ctrl) else $error("device drove before a read byte");
endmodule
`default_nettype wire

// >>> tb/sensor_spi_slave_port_test.sv
// self-checking bench joining the master end and the sensor port end
`timescale 1ns/10ps
`default_nettype none
module sensor_spi_slave_port_test;
    import ssp_pkg::*;
    logic clk, rst, cmd_start, cmd_rnw, cmd_mode11, tw, nv_lock;
    logic [6:0] cmd_addr, reg_addr;
    logic [3:0] cmd_len;
    logic [7:0] wr_data, rd_data, reg_wdata, reg_rdata;
    logic busy, wr_take, rd_valid, done, reg_wr, reg_rd, spi_active, three_wire, mode11;
    logic [7:0] mem [128];
    logic [7:0] rdq [$];
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;
    int n_rd = 0;
    ssp_link_if link ();
    // half period of 6 cycles leaves room for the device's edge latency
    ssp_host #(.SCLK_HALF(6), .LEN_W(4)) ssp_host_inst (.clk(clk), .rst(rst), .link(link),
        .cmd_start(cmd_start), .cmd_rnw(cmd_rnw), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
        .cmd_mode11(cmd_mode11), .three_wire(tw), .wr_data(wr_data), .busy(busy), .wr_take(wr_take),
        .rd_data(rd_data), .rd_valid(rd_valid), .done(done));
    ssp_device ssp_device_inst (.clk(clk), .rst(rst), .link(link), .nv_spi_lock(nv_lock),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .spi_active(spi_active), .three_wire(three_wire), .mode11(mode11));
    ssp_link_props ssp_link_props_inst (.clk(clk), .rst(rst), .chip_select_n(link.chip_select_n),
        .sclk(link.sclk), .host_sdx_o(link.host_sdx_o), .host_sdx_oe(link.host_sdx_oe),
        .dev_sdx_o(link.dev_sdx_o), .dev_sdx_oe(link.dev_sdx_oe), .dev_sdo_o(link.dev_sdo_o),
        .dev_sdo_oe(link.dev_sdo_oe));
    // register file behind the port; read data follows the address at once
    assign reg_rdata = mem[reg_addr];
    function automatic logic [7:0] pat(input int i);
        return 8'(i * 3) ^ 8'hC3;
    endfunction
    task automatic tally_and_finish();
        $display("mismatches %0d of %0d comparisons", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // write strobes, read bytes and the hang limit, all on the rising edge
    always @(posedge clk) begin
        if (reg_wr === 1'b1) begin
            mem[reg_addr] <= reg_wdata;
        end
        if (rd_valid === 1'b1) begin
            rdq.push_back(rd_data);
        end
        if (reg_rd === 1'b1) begin
            n_rd <= n_rd + 1;
        end
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_errors++;
            $display("mismatch at %0t: run did not complete", $time);
            tally_and_finish();
        end
    end
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic do_reset(input logic lock);
        @(negedge clk);
        rst = 1'b1;
        nv_lock = lock;
        tw = 1'b0;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
    endtask
    // one command; the next write byte is offered after each fetch
    task automatic xfer(input logic rnw, input logic [6:0] a, input logic [3:0] n, input logic m11,
                        input logic [7:0] b);
        @(negedge clk);
        cmd_rnw = rnw;
        cmd_addr = a;
        cmd_len = n;
        cmd_mode11 = m11;
        wr_data = b;
        cmd_start = 1'b1;
        @(negedge clk);
        cmd_start = 1'b0;
        check(busy, 8'h01);
        for (int k = 0; k < 3000 && done !== 1'b1; k++) begin
            @(negedge clk);
            if (wr_take === 1'b1) begin
                wr_data = wr_data + 8'h01;
            end
        end
        check(busy, 8'h00);
        if (done !== 1'b1) begin
            n_errors++;
            $display("mismatch at %0t: transfer did not complete", $time);
            tally_and_finish();
        end
    endtask
    task automatic wr_burst(input logic [6:0] a, input logic [3:0] n, input logic m11, input logic [7:0] b);
        xfer(1'b0, a, n, m11, b);
        for (int i = 0; i < n; i++) begin
            check(mem[7'(a + 7'(i))], 8'(b + 8'(i)));
        end
    endtask
    task automatic rd_burst(input logic [6:0] a, input logic [3:0] n, input logic m11);
        int rd_base;
        rdq.delete();
        rd_base = n_rd;
        xfer(1'b1, a, n, m11, 8'h00);
        check(8'(rdq.size()), 8'(n));
        check(8'(n_rd - rd_base), 8'(n) + 8'h01);
        for (int i = 0; i < n; i++) begin
            check(rdq[i], mem[7'(a + 7'(i))]);
        end
    endtask
    initial begin
        rst = 1'b1;
        nv_lock = 1'b0;
        tw = 1'b0;
        cmd_start = 1'b0;
        cmd_rnw = 1'b0;
        cmd_addr = 7'h00;
        cmd_len = 4'h1;
        cmd_mode11 = 1'b0;
        wr_data = 8'h00;
        for (int i = 0; i < 128; i++) begin
            mem[i] = pat(i);
        end
        do_reset(1'b0);
        check(spi_active, 8'h00);
        xfer(1'b0, 7'h10, 4'h1, 1'b0, 8'h77);
        check(mem[7'h10], pat(16));
        check(spi_active, 8'h01);
        rd_burst(ADDR_DUMMY, 4'h1, 1'b0);
        // both clock modes, single access, bursts through the address wrap
        for (int m = 0; m < 2; m++) begin
            wr_burst(7'(7'h20 + 7'(m * 8)), 4'h1, m[0], 8'h5A);
            check(mode11, 8'(m));
            wr_burst(7'h7E, 4'h3, m[0], 8'(8'h90 + 8'(m)));
            rd_burst(7'h7D, 4'h5, m[0]);
        end
        rd_burst(7'h00, 4'hF, 1'b1);
        wr_burst(ADDR_INTERFACE_CONFIG, 4'h1, 1'b0, 8'h01);
        check(three_wire, 8'h01);
        tw = 1'b1;
        wr_burst(7'h40, 4'h2, 1'b1, 8'h33);
        rd_burst(7'h3F, 4'h4, 1'b1);
        wr_burst(ADDR_NONVOLATILE_CONFIG, 4'h1, 1'b1, 8'h01);
        // second reset with the stored lock bit needs no select toggle
        do_reset(mem[ADDR_NONVOLATILE_CONFIG][SPI_LOCK_BIT]);
        check(spi_active, 8'h01);
        check(three_wire, 8'h00);
        rd_burst(7'h20, 4'h2, 1'b0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
